// [flash_ctrl_pkg.sv]
// Constants and carrier types shared by the flash program/erase controller
package flash_ctrl_pkg;

  // ==========================================================================
  // Array geometry
  localparam int WORD_W      = 32;                      // Bits per array word
  localparam int ADDR_W      = 16;                      // Word address width
  localparam int PAGE_COUNT  = 128;                     // Pages in the array
  localparam int ROW_COUNT   = 8;                       // Rows per page
  localparam int ROW_WORDS   = 64;                      // Words per row
  localparam int PAGE_WORDS  = ROW_COUNT * ROW_WORDS;   // 512 words per page
  localparam int ARRAY_WORDS = PAGE_COUNT * PAGE_WORDS; // 65536 words
  localparam int PAGE_LSB    = 9;                       // Page field low bit
  localparam int PAGE_MSB    = 15;                      // Page field high bit

  // Word addresses that hold the 64-bit protection secret
  localparam logic [15:0] LOCK_LO_ADDR = 16'hfffe;
  localparam logic [15:0] LOCK_HI_ADDR = 16'hffff;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_CONFIG  = 8'h04;
  localparam logic [7:0] OFS_MASKED  = 8'h08;
  localparam logic [7:0] OFS_IRQMASK = 8'h0c;
  localparam logic [7:0] OFS_IRQRAW  = 8'h10;
  localparam logic [7:0] OFS_SIZE    = 8'h14;
  localparam logic [7:0] OFS_ADDRESS = 8'h18;
  localparam logic [7:0] OFS_SIG     = 8'h24;
  localparam logic [7:0] OFS_BWORD0  = 8'h40;
  localparam logic [7:0] OFS_BWORD1  = 8'h44;
  localparam logic [7:0] OFS_BWORD2  = 8'h48;
  localparam logic [7:0] OFS_BWORD3  = 8'h4c;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] COMMAND_RST = 32'h00000000;
  localparam logic [31:0] CONFIG_RST  = 32'h00000000;
  localparam logic [5:0]  IRQMASK_RST = 6'h3f;
  localparam logic [15:0] ADDRESS_RST = 16'h0000;
  localparam logic [31:0] SIG_RST     = 32'h0fffffff;
  localparam logic [31:0] DATA_RST    = 32'h0fffffff;
  localparam logic [31:0] SIZE_VALUE  = 32'h00000000;
  localparam logic [31:0] SIG_SEED    = 32'hffffffff;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;

  // ==========================================================================
  // Event flag positions in the raw and masked status registers
  localparam int IRQ_W      = 6;
  localparam int FLG_DONE   = 0;
  localparam int FLG_START  = 1;
  localparam int FLG_BUSY   = 2;
  localparam int FLG_BADCMD = 3;
  localparam int FLG_PASS   = 4;
  localparam int FLG_NRDY   = 5;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h11;
  localparam logic [7:0] CMD_FULL_CLEAR = 8'h22;
  localparam logic [7:0] CMD_WORD_PROG  = 8'h33;
  localparam logic [7:0] CMD_FULL_FILL  = 8'h44;
  localparam logic [7:0] CMD_VERIFY     = 8'h55;
  localparam logic [7:0] CMD_MULTI_PROG = 8'hcc;

  // ==========================================================================
  // Timing
  localparam int  CLK_PERIOD_NS = 40;
  localparam real PAGE_ERASE_MS = 21.5;
  localparam real MASS_ERASE_MS = 21.5;
  localparam int  PROG_TIME_US  = 44;
  localparam int  BURST_STEP_US = 21;
  localparam int  TIMER_W       = 20;
  localparam int  PAGE_ERASE_CYCLES = int'($ceil(PAGE_ERASE_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  MASS_ERASE_CYCLES = int'($ceil(MASS_ERASE_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [19:0] PROG_CYCLES =
    20'((PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [19:0] BURST_STEP_CYCLES =
    20'((BURST_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Types
  typedef enum logic [9:0] {
    ST_BOOT_LO  = 10'h001,
    ST_BOOT_HI  = 10'h002,
    ST_BOOT_END = 10'h004,
    ST_IDLE     = 10'h008,
    ST_CLEAR    = 10'h010,
    ST_PROG     = 10'h020,
    ST_FILL     = 10'h040,
    ST_VERIFY   = 10'h080,
    ST_WAIT     = 10'h100,
    ST_FINISH   = 10'h200
  } seq_state_t;

  // Sequencer port of the array
  typedef struct packed {
    logic        we;
    logic        erase;
    logic [15:0] addr;
    logic [31:0] wdata;
  } array_cmd_t;

  // Host word-read request and answer
  typedef struct packed {
    logic        req;
    logic        debug;
    logic [15:0] addr;
  } host_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] data;
  } host_rsp_t;

endpackage

// [flash_array_mem.sv]
// Storage model of the embedded array: one sequencer port, one host read port
`timescale 1ns/1ps
module flash_array_mem (
  // Clock
  input  wire logic                     clk_i,
  // Sequencer port
  input  wire flash_ctrl_pkg::array_cmd_t a_i,
  output logic [31:0]                   a_rdata_o,
  // Host read port
  input  wire logic [15:0]              b_addr_i,
  output logic [31:0]                   b_rdata_o
);
  import flash_ctrl_pkg::*;

  logic [31:0] mem [ARRAY_WORDS] = '{default: ERASED_WORD};  // Cells, erased from manufacture

  // program clears bits only
  // Program only clears bits, erase returns the word to all ones
  always_ff @(posedge clk_i) begin
    if (a_i.we) begin
      if (a_i.erase) begin
        mem[a_i.addr] <= ERASED_WORD;
      end else begin
        mem[a_i.addr] <= mem[a_i.addr] & a_i.wdata;
      end
    end
    a_rdata_o <= mem[a_i.addr];
    b_rdata_o <= mem[b_addr_i];
  end

endmodule

// [signature_step.sv]
// One step of the 32-bit read signature: shift with feedback, then fold a word
`timescale 1ns/1ps
module signature_step (
  // Current signature and word read
  input  wire logic [31:0] cur_i,
  input  wire logic [31:0] word_i,
  // Next signature
  output logic [31:0]      nxt_o
);
  logic feedback;  // Taps of x32+x31+x4+x3+x1+1

  // Feedback from the taps, shifted in at the low end
  always_comb begin
    feedback = cur_i[31] ^ cur_i[30] ^ cur_i[3] ^ cur_i[2] ^ cur_i[0];
    nxt_o    = {cur_i[30:0], feedback} ^ word_i;
  end

endmodule

// [flash_program_erase_ctrl.sv]
// Flash program/erase sequencer with Wishbone registers and a host read port
//
// Behaviour
// - Array of 128 pages, 8x64 words, 32 bits
// - Program only clears bits; erase sets ones
// - Address splits into page, row and word
// - Host word read returns data like RAM
// - Verify sets pass flag only if all match
// - Verify folds words into LFSR signature
// - Code 0x55 starts a full verify
// - Started and finished flags per accepted command
// - Writing one clears a pending flag
// - Code 0x11 erases the addressed page
// - Code 0x22 erases the whole array
// - Code 0x33 programs one word
// - Code 0xCC programs four consecutive words
// - Code 0x44 fills array with data value
// - Locked and halted: reads zero, debug error
// - Lock also refuses debug RAM access
// - Non-blank secret in last words locks
// - Command while busy sets collision flag
// - Unknown code sets bad code flag
`timescale 1ns/1ps
module flash_program_erase_ctrl #(
  parameter logic [19:0] PAGE_ERASE_WAIT = 20'(flash_ctrl_pkg::PAGE_ERASE_CYCLES),
  parameter logic [19:0] MASS_ERASE_WAIT = 20'(flash_ctrl_pkg::MASS_ERASE_CYCLES)
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone register slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // Host word reads of the array
  input  wire flash_ctrl_pkg::host_req_t host_i,
  input  wire logic                      core_halted_i,
  output flash_ctrl_pkg::host_rsp_t      host_o,
  // Protection towards RAM debug path
  output logic                           ram_debug_deny_o
);
  import flash_ctrl_pkg::*;

  // ==========================================================================
  // Functions

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Recognised command codes
  function automatic logic known_code(input logic [7:0] code);
    return (code == CMD_PAGE_ERASE) || (code == CMD_FULL_CLEAR) ||
           (code == CMD_WORD_PROG)  || (code == CMD_FULL_FILL)  ||
           (code == CMD_VERIFY)     || (code == CMD_MULTI_PROG);
  endfunction

  // ==========================================================================
  // State
  seq_state_t        state, next_state;        // Sequencer state
  logic [7:0]        op, next_op;              // Command in execution
  logic [16:0]       cnt, next_cnt;            // Words left, or last burst index
  logic [15:0]       ptr, next_ptr;            // Walking word address
  logic [2:0]        idx, next_idx;            // Burst word index
  logic [19:0]       timer, next_timer;        // Array settle time left
  logic [31:0]       sig, next_sig;            // Running signature
  logic              match, next_match;        // All words equal so far
  logic              pend, next_pend;          // Verify read in flight
  logic [31:0]       lock_lo, next_lock_lo;    // Shadow of secret low word
  logic [31:0]       lock_hi, next_lock_hi;    // Shadow of secret high word
  logic [31:0]       command, next_command;    // Last written command
  logic [31:0]       config_r, next_config;    // Wrapper configuration
  logic [IRQ_W-1:0]  raw, next_raw;            // Sticky event flags
  logic [IRQ_W-1:0]  mask, next_mask;          // Event mask
  logic [15:0]       address, next_address;    // Target word address
  logic [3:0][31:0]  data_q, next_data;        // Program data words
  logic [31:0]       lfsr_val, next_lfsr;      // Signature after verify
  logic [31:0]       next_rdat;                // Bus read data
  logic              next_ack;                 // Bus acknowledge
  logic              hq_req, hq_blk, hq_dbg;   // Host read in flight
  host_rsp_t         next_host;                // Host answer
  logic              next_deny;                // RAM debug refusal

  // Combinational helpers
  array_cmd_t        arr;                      // Sequencer port drive
  logic [31:0]       a_rdata, b_rdata;         // Array read data
  logic [31:0]       sig_step;                 // Signature after one fold
  logic [IRQ_W-1:0]  ev, clr;                  // Flag set and clear terms
  logic              wr_fire;                  // Bus write takes effect
  logic              lock_active;              // Protection lock in force
  logic [2:0]        prog_words;               // Burst words to program

  // ==========================================================================
  // Submodules

  // Array storage
  flash_array_mem u_array (
    .clk_i     (clk_i),
    .a_i       (arr),
    .a_rdata_o (a_rdata),
    .b_addr_i  (host_i.addr),
    .b_rdata_o (b_rdata)
  );

  // Signature fold of the word returned to the verify walk
  signature_step u_sig (
    .cur_i  (sig),
    .word_i (a_rdata),
    .nxt_o  (sig_step)
  );

  // ==========================================================================
  // Next-state logic
  always_comb begin
    // Hold everything by default except pend, which clears
    next_state   = state;
    next_op      = op;
    next_cnt     = cnt;
    next_ptr     = ptr;
    next_idx     = idx;
    next_timer   = timer;
    next_sig     = sig;
    next_match   = match;
    next_pend    = 1'b0;
    next_lock_lo = lock_lo;
    next_lock_hi = lock_hi;
    next_command = command;
    next_config  = config_r;
    next_mask    = mask;
    next_address = address;
    next_data    = data_q;
    next_lfsr    = lfsr_val;
    ev           = '0;
    clr          = '0;
    arr          = '{we: 1'b0, erase: 1'b0, addr: ptr, wdata: data_q[0]};
    lock_active  = ({lock_hi, lock_lo} != {ERASED_WORD, ERASED_WORD});
    prog_words   = '0;
    for (int w = 0; w < 4; w++) begin
      if (data_q[w] != ERASED_WORD) begin
        prog_words = prog_words + 3'h1;
      end
    end

    // Sequencer
    case (state)
      // Catch the secret words into the lock shadows
      ST_BOOT_LO: begin
        arr.addr   = LOCK_LO_ADDR;
        next_state = ST_BOOT_HI;
      end
      ST_BOOT_HI: begin
        arr.addr     = LOCK_HI_ADDR;
        next_lock_lo = a_rdata;
        next_state   = ST_BOOT_END;
      end
      ST_BOOT_END: begin
        next_lock_hi = a_rdata;
        next_state   = ST_IDLE;
      end
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_CLEAR: begin
        arr.we    = 1'b1;
        arr.erase = 1'b1;
        next_ptr  = ptr + 16'h1;
        next_cnt  = cnt - 17'h1;
        if (cnt == 17'h1) begin
          next_state = ST_WAIT;
        end
      end
      ST_PROG: begin
        arr.we    = 1'b1;
        arr.addr  = ptr + {13'h0, idx};
        arr.wdata = data_q[idx[1:0]];
        next_idx  = idx + 3'h1;
        if (idx[1:0] == cnt[1:0]) begin
          next_state = ST_WAIT;
        end
      end
      // fill every word with the data value
      ST_FILL: begin
        arr.we   = 1'b1;
        next_ptr = ptr + 16'h1;
        next_cnt = cnt - 17'h1;
        if (cnt == 17'h1) begin
          next_state = ST_FINISH;
        end
      end
      // read walk with compare and signature
      ST_VERIFY: begin
        if (cnt != 17'h0) begin
          next_ptr = ptr + 16'h1;
          next_cnt = cnt - 17'h1;
        end
        next_pend = (cnt != 17'h0);
        if (pend) begin
          next_sig   = sig_step;
          next_match = match & (a_rdata == data_q[0]);
          if (cnt == 17'h0) begin
            next_lfsr      = sig_step;
            ev[FLG_PASS]   = next_match;
            next_state     = ST_FINISH;
          end
        end
      end
      // Array settle time
      ST_WAIT: begin
        next_timer = timer - 20'h1;
        if (timer <= 20'h1) begin
          next_state = ST_FINISH;
        end
      end
      // completion flag, address steps past the words written by a 0x33 or 0xCC program
      ST_FINISH: begin
        ev[FLG_DONE] = 1'b1;
        if (op == CMD_WORD_PROG) begin
          next_address = address + 16'h1;
        end else if (op == CMD_MULTI_PROG) begin
          next_address = address + 16'h4;
        end
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // keep lock shadows in step with array writes
    if (arr.we && (arr.addr == LOCK_LO_ADDR)) begin
      next_lock_lo = arr.erase ? ERASED_WORD : (lock_lo & arr.wdata);
    end
    if (arr.we && (arr.addr == LOCK_HI_ADDR)) begin
      next_lock_hi = arr.erase ? ERASED_WORD : (lock_hi & arr.wdata);
    end

    // Bus slave: ack one cycle after the request, write at the acked edge
    next_ack  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr_fire   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    next_rdat = wb_dat_o;
    if (next_ack && !wb_we_i) begin
      case ({wb_adr_i[7:2], 2'b00})
        OFS_COMMAND: next_rdat = command;
        OFS_CONFIG:  next_rdat = config_r;
        OFS_MASKED:  next_rdat = {26'h0, raw & mask};
        OFS_IRQMASK: next_rdat = {26'h0, mask};
        OFS_IRQRAW:  next_rdat = {26'h0, raw};
        OFS_SIZE:    next_rdat = SIZE_VALUE;
        OFS_ADDRESS: next_rdat = {16'h0, address};
        OFS_SIG:     next_rdat = lfsr_val;
        OFS_BWORD0:  next_rdat = data_q[0];
        OFS_BWORD1:  next_rdat = data_q[1];
        OFS_BWORD2:  next_rdat = data_q[2];
        OFS_BWORD3:  next_rdat = data_q[3];
        default:     next_rdat = 32'h0;
      endcase
    end

    // Register writes
    if (wr_fire) begin
      case ({wb_adr_i[7:2], 2'b00})
        OFS_COMMAND: begin
          next_command = apply_sel(command, wb_dat_i, wb_sel_i);
          if (state != ST_IDLE) begin
            ev[FLG_BUSY] = 1'b1;
          end else if (!wb_sel_i[0] || !known_code(wb_dat_i[7:0])) begin
            ev[FLG_BADCMD] = 1'b1;
          end else begin
            ev[FLG_START] = 1'b1;
            next_op       = wb_dat_i[7:0];
            next_idx      = 3'h0;
            next_ptr      = 16'h0;
            next_cnt      = 17'(ARRAY_WORDS);
            next_timer    = MASS_ERASE_WAIT;
            case (wb_dat_i[7:0])
              CMD_PAGE_ERASE: begin
                next_ptr   = {address[PAGE_MSB:PAGE_LSB], 9'h000};
                next_cnt   = 17'(PAGE_WORDS);
                next_timer = PAGE_ERASE_WAIT;
                next_state = ST_CLEAR;
              end
              CMD_FULL_CLEAR: next_state = ST_CLEAR;
              CMD_WORD_PROG: begin
                next_ptr   = address;
                next_cnt   = 17'h0;
                next_timer = PROG_CYCLES;
                next_state = ST_PROG;
              end
              CMD_MULTI_PROG: begin
                next_ptr   = address;
                next_cnt   = 17'h3;
                next_timer = (prog_words > 3'h1)
                           ? PROG_CYCLES + BURST_STEP_CYCLES * 20'(prog_words - 3'h1)
                           : PROG_CYCLES;
                next_state = ST_PROG;
              end
              CMD_FULL_FILL: next_state = ST_FILL;
              CMD_VERIFY: begin
                next_sig   = SIG_SEED;
                next_match = 1'b1;
                next_state = ST_VERIFY;
              end
              default: next_state = ST_IDLE;
            endcase
          end
        end
        OFS_CONFIG:  next_config = apply_sel(config_r, wb_dat_i, wb_sel_i);
        OFS_MASKED:  clr = wb_dat_i[IRQ_W-1:0] & {IRQ_W{wb_sel_i[0]}};
        OFS_IRQRAW:  clr = wb_dat_i[IRQ_W-1:0] & {IRQ_W{wb_sel_i[0]}};
        OFS_IRQMASK: begin
          if (wb_sel_i[0]) begin
            next_mask = wb_dat_i[IRQ_W-1:0];
          end
        end
        OFS_ADDRESS: next_address = 16'(apply_sel({16'h0, address}, wb_dat_i, wb_sel_i));
        OFS_BWORD0:  next_data[0] = apply_sel(data_q[0], wb_dat_i, wb_sel_i);
        OFS_BWORD1:  next_data[1] = apply_sel(data_q[1], wb_dat_i, wb_sel_i);
        OFS_BWORD2:  next_data[2] = apply_sel(data_q[2], wb_dat_i, wb_sel_i);
        OFS_BWORD3:  next_data[3] = apply_sel(data_q[3], wb_dat_i, wb_sel_i);
        default:     next_config = config_r;
      endcase
    end

    // a new event wins over a clear in the same cycle
    next_raw = (raw & ~clr) | ev;

    // host answer, zeroed when locked and halted
    next_host.valid = hq_req;
    next_host.err   = hq_req & hq_blk & hq_dbg;
    next_host.data  = (hq_req && !hq_blk) ? b_rdata : 32'h0;
    // refuse debug RAM access while locked
    next_deny       = lock_active;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state            <= ST_BOOT_LO;
      op               <= 8'h00;
      cnt              <= 17'h0;
      ptr              <= 16'h0;
      idx              <= 3'h0;
      timer            <= 20'h0;
      sig              <= SIG_SEED;
      match            <= 1'b0;
      pend             <= 1'b0;
      lock_lo          <= ERASED_WORD;
      lock_hi          <= ERASED_WORD;
      command          <= COMMAND_RST;
      config_r         <= CONFIG_RST;
      raw              <= '0;
      mask             <= IRQMASK_RST;
      address          <= ADDRESS_RST;
      data_q           <= {4{DATA_RST}};
      lfsr_val         <= SIG_RST;
      wb_dat_o         <= 32'h0;
      wb_ack_o         <= 1'b0;
      hq_req           <= 1'b0;
      hq_blk           <= 1'b0;
      hq_dbg           <= 1'b0;
      host_o           <= '0;
      ram_debug_deny_o <= 1'b0;
    end else begin
      state            <= next_state;
      op               <= next_op;
      cnt              <= next_cnt;
      ptr              <= next_ptr;
      idx              <= next_idx;
      timer            <= next_timer;
      sig              <= next_sig;
      match            <= next_match;
      pend             <= next_pend;
      lock_lo          <= next_lock_lo;
      lock_hi          <= next_lock_hi;
      command          <= next_command;
      config_r         <= next_config;
      raw              <= next_raw;
      mask             <= next_mask;
      address          <= next_address;
      data_q           <= next_data;
      lfsr_val         <= next_lfsr;
      wb_dat_o         <= next_rdat;
      wb_ack_o         <= next_ack;
      // protection decided when the read is taken
      hq_req           <= host_i.req;
      hq_blk           <= host_i.req & lock_active & core_halted_i;
      hq_dbg           <= host_i.debug;
      host_o           <= next_host;
      ram_debug_deny_o <= next_deny;
    end
  end

endmodule

// [flash_ctrl_asserts.sv]
// Port checker for the flash program/erase controller
`timescale 1ns/1ps
module flash_ctrl_asserts (
  // Watched ports
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_ack_o,
  input wire flash_ctrl_pkg::host_req_t host_i,
  input wire logic                      core_halted_i,
  input wire flash_ctrl_pkg::host_rsp_t host_o,
  input wire logic                      ram_debug_deny_o
);
  import flash_ctrl_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without strobe");
  read_lat_a: assert property (host_i.req |-> ##2 host_o.valid)
    else $error("read answer late");
  valid_cause_a: assert property (host_o.valid |-> $past(host_i.req, 2))
    else $error("answer without request");
  open_read_a: assert property (host_i.req && !core_halted_i |-> ##2 !host_o.err)
    else $error("error while running");
  lock_zero_a: assert property (host_i.req && core_halted_i && ram_debug_deny_o
    |-> ##2 host_o.data == 32'h0) else $error("locked data leaked");
  lock_err_a: assert property (host_i.req && core_halted_i && ram_debug_deny_o
    |-> ##2 host_o.err == $past(host_i.debug, 2)) else $error("locked error wrong");
endmodule
bind flash_program_erase_ctrl flash_ctrl_asserts flash_ctrl_asserts_inst (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .host_i, .core_halted_i, .host_o, .ram_debug_deny_o);

// [host_reader.sv]
// Host read master in front of the array read port
`timescale 1ns/1ps
module host_reader (
  // Clock and answer
  input  wire logic                      clk_i,
  input  wire flash_ctrl_pkg::host_rsp_t rsp_i,
  // Request
  output flash_ctrl_pkg::host_req_t      req_o
);
  import flash_ctrl_pkg::*;
  initial req_o = '0;
  // One request pulse; released address is scrambled; answer two cycles on
  task automatic rd(input logic [15:0] a, input logic g, output host_rsp_t r);
    @(posedge clk_i) req_o <= '{1'b1, g, a};
    @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a};
    repeat (2) @(posedge clk_i);
    r = rsp_i;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
module tb;
  import flash_ctrl_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0, ack, deny;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q, sig;
  logic [31:0] bw [4] = '{32'h11111111, 32'h22222222, 32'hffffffff, 32'h44444444};
  host_req_t   hq;
  host_rsp_t   hr;
  int          bad_count = 0, samples_checked = 0;
  initial forever #20 clk_i = ~clk_i;
  flash_program_erase_ctrl #(.PAGE_ERASE_WAIT(20'd20), .MASS_ERASE_WAIT(20'd20))
    flash_program_erase_ctrl_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .host_i(hq), .core_halted_i(halt), .host_o(hr), .ram_debug_deny_o(deny));
  host_reader host_reader_inst (.clk_i, .rsp_i(hr), .req_o(hq));
  // Classic single Wishbone cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Command, optional colliding command, poll until done, then clear all flags
  task automatic run(input logic [7:0] c, input logic [7:0] c2);
    logic [31:0] f;
    wb(1'b1, OFS_COMMAND, {24'h0, c});
    if (c2 != 8'h00) wb(1'b1, OFS_COMMAND, {24'h0, c2});
    do wb(1'b0, OFS_IRQRAW, 32'h0); while (q[FLG_DONE] !== 1'b1);
    f = q;
    wb(1'b1, OFS_MASKED, 32'h3f);
    wb(1'b0, OFS_IRQRAW, 32'h0);
    chk("flags_cleared", 32'h0, q);
    q = f;
  endtask
  // Host word read; a bus error is expected only for debug reads here
  task automatic hrd(input logic [15:0] a, input logic g, input logic [31:0] e);
    host_rsp_t r;
    host_reader_inst.rd(a, g, r);
    chk("host_valid", 32'h1, {31'h0, r.valid});
    chk("host_data", e, r.data);
    chk("host_err", {31'h0, g}, {31'h0, r.err});
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk_i);
    $display("FAIL watchdog expected done seen timeout");
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, OFS_IRQMASK, 32'h0);
    chk("mask", 32'h3f, q);
    sig = 32'hffffffff;
    for (int i = 0; i < 65536; i++)
      sig = {sig[30:0], sig[31] ^ sig[30] ^ sig[3] ^ sig[2] ^ sig[0]} ^ 32'hffffffff;
    wb(1'b1, OFS_BWORD0, 32'hffffffff);
    run(CMD_VERIFY, 8'h00);
    chk("verify_flags", 32'h13, q);
    wb(1'b0, OFS_SIG, 32'h0);
    chk("signature", sig, q);
    wb(1'b1, OFS_ADDRESS, 32'h0203);
    wb(1'b1, OFS_BWORD0, 32'h12345678);
    run(CMD_WORD_PROG, CMD_PAGE_ERASE);
    chk("busy_flags", 32'h7, q);
    hrd(16'h0203, 1'b0, 32'h12345678);
    wb(1'b1, OFS_ADDRESS, 32'h0203);
    wb(1'b1, OFS_BWORD0, 32'hff00ffff);
    run(CMD_WORD_PROG, 8'h00);
    hrd(16'h0203, 1'b0, 32'h12005678);
    wb(1'b1, OFS_ADDRESS, 32'h0400);
    for (int i = 0; i < 4; i++) wb(1'b1, OFS_BWORD0 + 8'(4 * i), bw[i]);
    run(CMD_MULTI_PROG, 8'h00);
    for (int i = 0; i < 4; i++) hrd(16'h0400 + 16'(i), 1'b0, bw[i]);
    wb(1'b1, OFS_ADDRESS, 32'h0200);
    run(CMD_PAGE_ERASE, 8'h00);
    hrd(16'h0203, 1'b0, 32'hffffffff);
    hrd(16'h0400, 1'b0, bw[0]);
    wb(1'b1, OFS_COMMAND, 32'h77);
    wb(1'b0, OFS_IRQRAW, 32'h0);
    chk("bad_code", 32'h8, q);
    wb(1'b1, OFS_ADDRESS, 32'hfffe);
    wb(1'b1, OFS_BWORD0, 32'h0);
    run(CMD_WORD_PROG, 8'h00);
    chk("deny", 32'h1, {31'h0, deny});
    halt <= 1'b1;
    hrd(16'h0400, 1'b1, 32'h0);
    hrd(16'h0400, 1'b0, 32'h0);
    tally_and_finish();
  end
endmodule
